// [verif/fpi_iu_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////
// Integer-unit side: answers the exception request
module fpi_iu_model #(
	parameter int ACK_DELAY = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Exception handshake
	input wire logic fp_exception_req_n_i,
	output logic fp_exception_ack_o
);
	// Cycles the request has waited
	int wait_reg;
	// Acknowledge after a delay, hold it until the request drops
	// ack until request released
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || fp_exception_req_n_i) begin
			wait_reg <= 0;
			fp_exception_ack_o <= 1'h0;
		end else begin
			wait_reg <= wait_reg + 1;
			fp_exception_ack_o <= (wait_reg >= ACK_DELAY);
		end
	end
endmodule : fpi_iu_model

// [verif/test_fpi_interlock.sv]
`timescale 1ns/10ps
////////////////////////////////////////
// Self-checking bench for the pipeline interlock
module test_fpi_interlock;
	import fpi_pkg::*;
	// Stimulus
	logic clk_i = 0, sys_rst_i = 1, clk_en_i = 1;
	fpi_mem_hold_type mem_hold_i = 3'h7;
	logic coproc_hold_n_i = 1, coproc_cond_valid_i = 1;
	logic select_last_fetched_i = 0, select_second_last_fetched_i = 0;
	fpi_instr_type instr_i;
	logic op_complete_i = 0, cond_codes_ready_i = 0;
	logic exception_event_i = 0, handler_done_i = 0;
	// Observed
	logic fp_exception_ack_i, fpu_hold_n_o, fp_cond_valid_o, freeze_notice_o;
	logic fp_exception_req_n_o, pipeline_freeze_o, sequence_error_o, queue_full_o;
	int fail_count = 0;
	int comparisons = 0;

	fpi_interlock u_dut (.clk_i, .sys_rst_i, .clk_en_i, .mem_hold_i, .coproc_hold_n_i,
		.coproc_cond_valid_i, .select_last_fetched_i, .select_second_last_fetched_i,
		.instr_i, .op_complete_i, .cond_codes_ready_i, .exception_event_i,
		.handler_done_i, .fp_exception_ack_i, .fpu_hold_n_o, .fp_cond_valid_o,
		.freeze_notice_o, .fp_exception_req_n_o, .pipeline_freeze_o, .sequence_error_o,
		.queue_full_o);
	fpi_iu_model #(.ACK_DELAY(2)) u_iu (.clk_i, .sys_rst_i,
		.fp_exception_req_n_i(fp_exception_req_n_o), .fp_exception_ack_o(fp_exception_ack_i));

	// 100 MHz clock
	always #5 clk_i = !clk_i;

	////////////////////////////////////////
	// Shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic issue(input fpi_kind_type k, input logic [4:0] d, s1, s2, input logic sec);
		instr_i = '{k, d, s1, s2, 1'h1, 1'h1};
		// select picks last or second-last fetch
		select_last_fetched_i = !sec;
		select_second_last_fetched_i = sec;
	endtask : issue
	task automatic idle();
		issue(FPI_K_NONE, 5'h0, 5'h0, 5'h0, 1'h0);
		select_last_fetched_i = 1'h0;
	endtask : idle
	task automatic op_done(input int n);
		op_complete_i = 1'h1;
		tick(n);
		op_complete_i = 1'h0;
	endtask : op_done
	task automatic complete_run();
		if (fail_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	////////////////////////////////////////
	// Scenarios
	task automatic t_freeze();
		for (int i = 0; i < 5; i++) begin
			{mem_hold_i, coproc_hold_n_i, coproc_cond_valid_i} = 5'h1F ^ (5'h1 << i);
			tick(1);
			check(pipeline_freeze_o, 1'h1);
			{mem_hold_i, coproc_hold_n_i, coproc_cond_valid_i} = 5'h1F;
			tick(1);
			check(pipeline_freeze_o, 1'h0);
		end
		// Arithmetic offered while frozen is not queued
		mem_hold_i.memory_hold_a_n = 1'h0;
		issue(FPI_K_ARITH, 5'h8, 5'h0, 5'h0, 1'h0);
		tick(1);
		mem_hold_i.memory_hold_a_n = 1'h1;
		issue(FPI_K_STORE, 5'h8, 5'h0, 5'h0, 1'h0);
		tick(2);
		check(fpu_hold_n_o, 1'h1);
		// Queued work retires during a freeze
		issue(FPI_K_ARITH, 5'h7, 5'h0, 5'h0, 1'h0);
		tick(1);
		idle();
		mem_hold_i.bus_memory_hold_n = 1'h0;
		op_done(1);
		mem_hold_i.bus_memory_hold_n = 1'h1;
		issue(FPI_K_STORE, 5'h7, 5'h0, 5'h0, 1'h0);
		tick(2);
		check(fpu_hold_n_o, 1'h1);
		idle();
	endtask : t_freeze

	task automatic t_deps();
		issue(FPI_K_ARITH, 5'h3, 5'h5, 5'h6, 1'h0);
		tick(1);
		issue(FPI_K_LOAD, 5'h9, 5'h0, 5'h0, 1'h0);
		tick(2);
		check(fpu_hold_n_o, 1'h1);
		issue(FPI_K_LOAD, 5'h5, 5'h0, 5'h0, 1'h0);
		tick(2);
		// load hit raises hold and freeze on the falling edge, notice on the next rising edge
		check({fpu_hold_n_o, freeze_notice_o, pipeline_freeze_o}, 3'h3);
		issue(FPI_K_STORE, 5'h5, 5'h0, 5'h0, 1'h0);
		tick(2);
		check(fpu_hold_n_o, 1'h1);
		issue(FPI_K_STORE, 5'h3, 5'h0, 5'h0, 1'h0);
		tick(2);
		check(fpu_hold_n_o, 1'h0);
		issue(FPI_K_SREG, 5'h0, 5'h0, 5'h0, 1'h0);
		tick(2);
		check(fpu_hold_n_o, 1'h0);
		op_done(1);
		tick(2);
		check({fpu_hold_n_o, freeze_notice_o}, 2'h2);
		idle();
	endtask : t_deps

	task automatic t_full();
		for (int i = 0; i < 4; i++) begin
			issue(FPI_K_ARITH, 5'(i + 16), 5'h0, 5'h0, 1'h0);
			tick(1);
		end
		idle();
		check(queue_full_o, 1'h1);
		issue(FPI_K_ARITH, 5'h1, 5'h0, 5'h0, 1'h1);
		tick(2);
		check(fpu_hold_n_o, 1'h0);
		idle();
		op_done(4);
		tick(2);
		check({queue_full_o, fpu_hold_n_o}, 2'h1);
	endtask : t_full

	task automatic t_enable();
		// Low clock enable keeps an offered operation out of the queue
		clk_en_i = 1'h0;
		issue(FPI_K_ARITH, 5'hA, 5'h0, 5'h0, 1'h0);
		tick(2);
		idle();
		clk_en_i = 1'h1;
		issue(FPI_K_STORE, 5'hA, 5'h0, 5'h0, 1'h0);
		tick(2);
		check(fpu_hold_n_o, 1'h1);
		idle();
	endtask : t_enable

	task automatic t_compare();
		issue(FPI_K_CMP, 5'h0, 5'h1, 5'h2, 1'h0);
		tick(1);
		idle();
		tick(1);
		check({fp_cond_valid_o, freeze_notice_o}, 2'h1);
		cond_codes_ready_i = 1'h1;
		tick(1);
		cond_codes_ready_i = 1'h0;
		check(fp_cond_valid_o, 1'h0);
		tick(1);
		check(fp_cond_valid_o, 1'h0);
		tick(1);
		check(fp_cond_valid_o, 1'h1);
		check(freeze_notice_o, 1'h0);
	endtask : t_compare

	task automatic t_exception();
		int n;
		int nh;
		int ns;
		nh = 0;
		ns = 0;
		issue(FPI_K_ARITH, 5'h3, 5'h0, 5'h0, 1'h0);
		tick(1);
		issue(FPI_K_LOAD, 5'h3, 5'h0, 5'h0, 1'h0);
		tick(2);
		exception_event_i = 1'h1;
		tick(1);
		exception_event_i = 1'h0;
		check({fp_exception_req_n_o, fpu_hold_n_o}, 2'h0);
		// Held load stays presented until the trap is taken
		tick(1);
		check(fpu_hold_n_o, 1'h0);
		tick(1);
		check({fp_exception_req_n_o, fpu_hold_n_o}, 2'h1);
		for (n = 0; n < 20 && fp_exception_req_n_o !== 1'h1; n++)
			tick(1);
		if (n == 20) begin
			fail_count++;
			complete_run();
		end
		idle();
		check(fpu_hold_n_o, 1'h1);
		// Load while in exception mode
		issue(FPI_K_LOAD, 5'h4, 5'h0, 5'h0, 1'h0);
		for (n = 0; n < 6; n++) begin
			tick(1);
			idle();
			nh += (fpu_hold_n_o === 1'h0);
			ns += (sequence_error_o === 1'h1);
		end
		check(8'(nh), 8'h1);
		check(8'(ns), 8'h1);
		op_done(1);
		handler_done_i = 1'h1;
		tick(1);
		handler_done_i = 1'h0;
		issue(FPI_K_LOAD, 5'h4, 5'h0, 5'h0, 1'h0);
		tick(2);
		check({sequence_error_o, fp_exception_req_n_o}, 2'h1);
		idle();
	endtask : t_exception

	////////////////////////////////////////
	// Main sequence
	initial begin
		idle();
		tick(4);
		sys_rst_i = 1'h0;
		check({fpu_hold_n_o, fp_cond_valid_o, freeze_notice_o, fp_exception_req_n_o,
			sequence_error_o, queue_full_o}, 6'h34);
		t_freeze();
		t_deps();
		t_full();
		t_enable();
		t_compare();
		t_exception();
		complete_run();
	end
endmodule : test_fpi_interlock

// [verilog/fpi_interlock.sv]
// Contract
// RULE1: freeze on any hold or missing valid
// RULE2: freeze stalls fetch, decode, execute stages
// RULE3: proceed only when all clear together
// RULE4: queued operations keep running while frozen
// RULE5: notice follows hold or lost valid
// RULE6: notice on rising, hold on falling edge
// RULE7: system stops issue using notice only
// RULE8: hold load hitting queued operand fields
// RULE9: hold store reading pending destination
// RULE10: status transfer waits for empty queue
// RULE11: checks include unimplemented queued operations
// RULE12: trap taken in held store's execute
// RULE13: hold arithmetic issue when queue full
// RULE14: release hold entering exception mode
// RULE15: exception mode holds one cycle on error
// RULE16: drop hold one cycle after request
// RULE17: trap taken on the held instruction
// RULE18: request stands until acknowledge arrives
// RULE19: selects start last or second-last fetch
// RULE20: compare lowers valid, restores cycle later
// RULE21: load or arithmetic in exception errs
// RULE22: holds active low, valids active high
// RULE23: queue depth is a design parameter
`timescale 1ns/10ps
`include "fpi_map.svh"

module fpi_interlock (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// Memory and coprocessor holds, coprocessor valid
	input wire fpi_pkg::fpi_mem_hold_type mem_hold_i,
	input wire logic coproc_hold_n_i,
	input wire logic coproc_cond_valid_i,
	// Instruction selects and decoded instruction
	input wire logic select_last_fetched_i,
	input wire logic select_second_last_fetched_i,
	input wire fpi_pkg::fpi_instr_type instr_i,
	// Datapath events
	input wire logic op_complete_i,
	input wire logic cond_codes_ready_i,
	input wire logic exception_event_i,
	input wire logic handler_done_i,
	// Integer unit acknowledge
	input wire logic fp_exception_ack_i,
	// Pipeline outputs
	output logic fpu_hold_n_o,
	output logic fp_cond_valid_o,
	output logic freeze_notice_o,
	output logic fp_exception_req_n_o,
	output logic pipeline_freeze_o,
	output logic sequence_error_o,
	output logic queue_full_o
);
	import fpi_pkg::*;

	localparam int QD = `FPI_Q_DEPTH;
	localparam int PW = $clog2(QD);

	////////////////////////////////////////////////////////////////////////////
	// State
	fpi_qent_type queue_reg [QD];      // Operation queue copy
	logic [PW-1:0] head_reg;           // Oldest entry
	logic [PW-1:0] tail_reg;           // Next free entry
	logic [PW:0] count_reg;            // Occupancy
	fpi_mode_type mode_reg;            // Handshake mode
	logic req_seen_reg;                // Request stood one cycle
	logic cmp_wait_reg;                // Waiting for condition codes
	logic cmp_tail_reg;                // Extra cycle of low valid
	logic seq_err_reg;                 // Sequence error pulse
	logic hold_n_reg;                  // Falling-edge hold
	logic ccv_reg;                     // Falling-edge valid
	logic notice_reg;                  // Rising-edge notice
	logic req_n_reg;                   // Exception request

	////////////////////////////////////////////////////////////////////////////
	// Decode of the incoming instruction
	wire issue = select_last_fetched_i | select_second_last_fetched_i;
	wire is_arith = issue & (instr_i.kind == FPI_K_ARITH);
	wire is_load = issue & (instr_i.kind == FPI_K_LOAD);
	wire is_store = issue & (instr_i.kind == FPI_K_STORE);
	wire is_sreg = issue & (instr_i.kind == FPI_K_SREG);
	wire is_cmp = issue & (instr_i.kind == FPI_K_CMP);
	wire in_exec = (mode_reg == FPI_M_EXEC);
	wire in_pend = (mode_reg == FPI_M_PEND);
	wire in_excpt = (mode_reg == FPI_M_EXCPT);
	wire q_full = (count_reg == (PW+1)'(QD));
	wire q_empty = (count_reg == '0);

	////////////////////////////////////////////////////////////////////////////
	// Per-entry operand comparison
	logic [QD-1:0] load_hit;           // Load dest meets dest or a used source
	logic [QD-1:0] store_hit;          // Store source meets a dest
	genvar gi;
	generate
		for (gi = 0; gi < QD; gi++) begin : g_cmp
			// RULE8: load dest against all valid fields
			assign load_hit[gi] = queue_reg[gi].vld & (
				(queue_reg[gi].dest_field == instr_i.dest_field) |
				(queue_reg[gi].first_used &
				 (queue_reg[gi].first_source_field == instr_i.dest_field)) |
				(queue_reg[gi].second_used &
				 (queue_reg[gi].second_source_field == instr_i.dest_field)));
			// RULE9: store source against pending dest
			assign store_hit[gi] = queue_reg[gi].vld &
				(queue_reg[gi].dest_field == instr_i.dest_field);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Hold sources
	// RULE11: every queued operation is checked, implemented or not
	wire load_dep = is_load & (|load_hit);
	wire store_dep = is_store & (|store_hit);
	// RULE10: status transfer needs an idle queue
	wire sreg_dep = is_sreg & ~q_empty;
	// RULE13: arithmetic issue into a full queue
	wire full_dep = is_arith & q_full;
	wire dep_hold = load_dep | store_dep | sreg_dep | full_dep;
	// RULE14: exception mode holds only on sequence error
	// RULE15: one-cycle hold from the error pulse
	// RULE16: pending hold released after request stood a cycle
	wire hold_want = in_excpt ? seq_err_reg :
		in_pend ? (dep_hold & ~req_seen_reg) : dep_hold;
	// RULE20: valid low while codes pending and one cycle after
	wire ccv_want = ~(cmp_wait_reg | cmp_tail_reg);

	////////////////////////////////////////////////////////////////////////////
	// Pipeline freeze
	// RULE22: holds active low, valids active high
	wire any_hold = ~mem_hold_i.memory_hold_a_n | ~mem_hold_i.memory_hold_b_n |
		~mem_hold_i.bus_memory_hold_n | ~coproc_hold_n_i | ~hold_n_reg;
	wire any_invalid = ~coproc_cond_valid_i | ~ccv_reg;
	// RULE1: freeze combines all sources
	// RULE3: released only when all clear at once
	// RULE2: fetch, decode and execute stall on this level
	assign pipeline_freeze_o = any_hold | any_invalid;
	wire advance = ~pipeline_freeze_o & in_exec;
	// RULE19: either select starts an instruction in decode
	wire push = is_arith & advance & ~q_full;
	// RULE4: completion is not gated by the freeze
	wire pop = op_complete_i & ~q_empty;

	////////////////////////////////////////////////////////////////////////////
	// Queue occupancy
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			head_reg <= '0;
			tail_reg <= '0;
			count_reg <= '0;
		end else if (clk_en_i) begin
			// Pointers wrap at the parameter depth
			if (push) begin
				tail_reg <= (tail_reg == PW'(QD-1)) ? '0 : tail_reg + 1'b1;
			end
			if (pop) begin
				head_reg <= (head_reg == PW'(QD-1)) ? '0 : head_reg + 1'b1;
			end
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Queue entries
	generate
		for (gi = 0; gi < QD; gi++) begin : g_ent
			// RULE23: one entry per parameter slot
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					queue_reg[gi] <= '0;
				end else if (clk_en_i) begin
					// Fill at tail, drop at head
					if (push && tail_reg == PW'(gi)) begin
						queue_reg[gi] <= {1'b1, instr_i.dest_field,
							instr_i.first_source_field, instr_i.second_source_field,
							instr_i.first_used, instr_i.second_used};
					end else if (pop && head_reg == PW'(gi)) begin
						queue_reg[gi].vld <= 1'b0;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Mode and exception request
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_reg <= FPI_M_EXEC;
			req_n_reg <= `FPI_REQ_N_RST;
			req_seen_reg <= 1'b0;
		end else if (clk_en_i) begin
			req_seen_reg <= in_pend;
			case (mode_reg)
				// Raise request on a datapath exception
				FPI_M_EXEC: begin
					if (exception_event_i) begin
						mode_reg <= FPI_M_PEND;
						req_n_reg <= 1'b0;
					end
				end
				// RULE18: request stands until acknowledged
				FPI_M_PEND: begin
					if (fp_exception_ack_i) begin
						mode_reg <= FPI_M_EXCPT;
						req_n_reg <= 1'b1;
					end
				end
				// Handler drains queue then returns
				FPI_M_EXCPT: begin
					if (handler_done_i && q_empty) begin
						mode_reg <= FPI_M_EXEC;
					end
				end
				default: begin
					mode_reg <= FPI_M_EXEC;
				end
			endcase
		end
	end

	// Compare tracking and sequence error
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cmp_wait_reg <= 1'b0;
			cmp_tail_reg <= 1'b0;
			seq_err_reg <= 1'b0;
		end else if (clk_en_i) begin
			// RULE20: wait for codes, then one more cycle
			cmp_wait_reg <= cmp_wait_reg ? ~cond_codes_ready_i : (is_cmp & advance);
			cmp_tail_reg <= cmp_wait_reg & cond_codes_ready_i;
			// RULE21: load or arithmetic in exception mode
			seq_err_reg <= in_excpt & (is_load | is_arith) & ~seq_err_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// RULE6: hold and valid move on the falling edge
	always_ff @(negedge clk_i) begin
		if (sys_rst_i) begin
			hold_n_reg <= `FPI_HOLD_N_RST;
			ccv_reg <= `FPI_CCV_RST;
		end else if (clk_en_i) begin
			hold_n_reg <= ~hold_want;
			ccv_reg <= ccv_want;
		end
	end

	// RULE5: notice on hold or lost valid
	// RULE7: one signal tells the system to stop issue
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			notice_reg <= `FPI_NOTICE_RST;
		end else if (clk_en_i) begin
			notice_reg <= hold_want | ~ccv_want;
		end
	end

	// Output drive
	assign fpu_hold_n_o = hold_n_reg;
	assign fp_cond_valid_o = ccv_reg;
	assign freeze_notice_o = notice_reg;
	assign fp_exception_req_n_o = req_n_reg;
	assign sequence_error_o = seq_err_reg;
	assign queue_full_o = q_full;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_mem_freeze: assert property ( // RULE1
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(!mem_hold_i.memory_hold_a_n || !coproc_hold_n_i || !fp_cond_valid_o)
		|-> pipeline_freeze_o)
		else $error("freeze missing for active hold");
	chk_clear_proceed: assert property ( // RULE3
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(&mem_hold_i && coproc_hold_n_i && fpu_hold_n_o && coproc_cond_valid_i
		 && fp_cond_valid_o) |-> !pipeline_freeze_o)
		else $error("freeze with all sources clear");
	chk_notice_follow: assert property ( // RULE5
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(!fpu_hold_n_o || !fp_cond_valid_o) |=> freeze_notice_o)
		else $error("notice missing after hold");
	// RULE6: notice as it stood at the falling edge
	logic notice_fall_reg;             // Notice captured on the falling edge
	always_ff @(negedge clk_i) begin
		notice_fall_reg <= freeze_notice_o;
	end
	// A notice that moved on the falling edge differs at the next rising edge
	chk_notice_edge: assert property ( // RULE6
		@(posedge clk_i) disable iff (sys_rst_i)
		freeze_notice_o == notice_fall_reg)
		else $error("notice changed on falling edge");
	// Hold moved at the falling edge, so it is low by the rising edge
	chk_load_dep: assert property ( // RULE8
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(in_exec && is_load && |load_hit) |-> !fpu_hold_n_o)
		else $error("load dependency not held");
	chk_store_dep: assert property ( // RULE9
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(in_exec && is_store && |store_hit) |-> !fpu_hold_n_o)
		else $error("store dependency not held");
	chk_full_hold: assert property ( // RULE13
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(in_exec && is_arith && count_reg == (PW+1)'(QD)) |-> !fpu_hold_n_o)
		else $error("full queue not held");
	chk_seq_pulse: assert property ( // RULE15
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(in_excpt && $fell(fpu_hold_n_o)) |=> fpu_hold_n_o)
		else $error("exception hold longer than one cycle");
	chk_hold_drop: assert property ( // RULE16
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		($fell(fp_exception_req_n_o) && !fpu_hold_n_o)
		|=> fpu_hold_n_o)
		else $error("hold not dropped after request");
	chk_req_stand: assert property ( // RULE18
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(!fp_exception_req_n_o && !fp_exception_ack_i) |=> !fp_exception_req_n_o)
		else $error("request dropped before acknowledge");
	chk_cmp_tail: assert property ( // RULE20
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(cmp_wait_reg && cond_codes_ready_i) |=> !fp_cond_valid_o ##1 fp_cond_valid_o)
		else $error("valid restored too early");
	chk_seq_error: assert property ( // RULE21
		@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
		(in_excpt && is_load && !seq_err_reg) |=> sequence_error_o)
		else $error("sequence error missed");

endmodule : fpi_interlock

// [verilog/fpi_map.svh]
`ifndef FPI_MAP_SVH
`define FPI_MAP_SVH

// Register-file field width of the operand specifiers
`define FPI_REG_W 5
// Operation queue depth used for the full check
`define FPI_Q_DEPTH 4
// Reset values of the pipeline-facing outputs
`define FPI_HOLD_N_RST 1'b1
`define FPI_CCV_RST 1'b1
`define FPI_REQ_N_RST 1'b1
`define FPI_NOTICE_RST 1'b0
// Sequence-error hold length in cycles
`define FPI_SEQ_HOLD_CYC 1

`endif

// [verilog/fpi_pkg.sv]
`include "fpi_map.svh"

package fpi_pkg;

	// Kind of the instruction being selected in decode
	typedef enum logic [5:0] {
		FPI_K_NONE = 6'h01,
		FPI_K_ARITH = 6'h02,
		FPI_K_LOAD = 6'h04,
		FPI_K_STORE = 6'h08,
		FPI_K_SREG = 6'h10,
		FPI_K_CMP = 6'h20
	} fpi_kind_type;

	// Operating mode of the exception handshake
	typedef enum logic [2:0] {
		FPI_M_EXEC = 3'h1,
		FPI_M_PEND = 3'h2,
		FPI_M_EXCPT = 3'h4
	} fpi_mode_type;

	// Decoded instruction presented with the select strobes
	typedef struct packed {
		fpi_kind_type kind;
		logic [`FPI_REG_W-1:0] dest_field;
		logic [`FPI_REG_W-1:0] first_source_field;
		logic [`FPI_REG_W-1:0] second_source_field;
		logic first_used;
		logic second_used;
	} fpi_instr_type;

	// One outstanding arithmetic operation in the queue
	typedef struct packed {
		logic vld;
		logic [`FPI_REG_W-1:0] dest_field;
		logic [`FPI_REG_W-1:0] first_source_field;
		logic [`FPI_REG_W-1:0] second_source_field;
		logic first_used;
		logic second_used;
	} fpi_qent_type;

	// Memory-side hold inputs, all active low
	typedef struct packed {
		logic memory_hold_a_n;
		logic memory_hold_b_n;
		logic bus_memory_hold_n;
	} fpi_mem_hold_type;

endpackage : fpi_pkg
